//--- core/rstk_filter.sv
// module: counting glitch filter for the master clear pin
`timescale 1ns/100ps
`default_nettype none
module rstk_filter
  import rstk_pkg::*;
#(
  parameter int FILT_CYC = RSTK_MASTER_CLEAR_PIN_FILT_CYC
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin_n,
  output logic level_n
);
  logic [7:0] cnt_q;
  logic level_q;
  // pulses shorter than the count never reach the output
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_q <= 8'h00;
      level_q <= 1'b1;
    end
    else if (pin_n == level_q)
    begin
      cnt_q <= 8'h00;
    end
    else if (cnt_q == 8'(FILT_CYC - 1))
    begin
      cnt_q <= 8'h00;
      level_q <= pin_n;
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign level_n = level_q;
endmodule
`default_nettype wire

//--- core/rstk_pkg.sv
// package: constants and types for the reset source tracker
// Functional notes
// - distinguish nine reset causes: por, master_clear_pin run, master_clear_pin sleep, wdt, cm, bor, instr, stack
// - low six status bits record reset events; software returns bits 5, 4, 1 and 0 to idle
// - bit 7 interrupt priority enable, resets to 0
// - bit 6 software brownout enable only when config field is 01, else reads 0
// - bit 5 mismatch flag reads 0 after mismatch reset, power-on value 1
// - bit 4 cleared by reset instruction, set by firmware, brownout and power-on
// - bit 3 read-only; set by power-up, watchdog clear, sleep; cleared by timeout
// - bit 2 read-only; set by power-up, watchdog clear; cleared by sleep
// - bit 1 cleared on power-on reset only; software sets it
// - bit 0 cleared on brownout reset; firmware sets; power-on value 0
// - master clear pin low resets device; short noise pulses filtered out
// - master clear pin is input only, never driven by internal resets
// - every wake applies fixed cpu start delay concurrently with other delays
// - crystal wake waits startup timer then sets startup flag; pll adds lock time
// - internal high/mid osc wake continues during stabilisation, sets stable flag
// - internal oscillator selection defaults to high-frequency source at 8 MHz
// - clock after wake depends on clock select, freq select and osc config fields
// - mismatch flag cleared on every mismatch event, set by power-on, unchanged by other resets
// - brownout flag cleared on brownout and on power-on reset
package rstk_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0] RSTK_ADDR_STATUS = 4'h0;
  localparam logic [3:0] RSTK_ADDR_OSC = 4'h1;
  localparam logic [3:0] RSTK_ADDR_CFG = 4'h2;
  localparam logic [3:0] RSTK_ADDR_CLKSTAT = 4'h3;
  localparam logic [3:0] RSTK_ADDR_CAUSE = 4'h4;
  // status bit positions
  localparam int RSTK_B_INTERRUPT_PRIORITY_ENABLE = 7;
  localparam int RSTK_B_SOFTWARE_BROWNOUT_ENABLE = 6;
  localparam int RSTK_B_CM = 5;
  localparam int RSTK_B_RI = 4;
  localparam int RSTK_B_TO = 3;
  localparam int RSTK_B_PD = 2;
  localparam int RSTK_B_POR = 1;
  localparam int RSTK_B_BOR = 0;
  // power-on value of the status register
  localparam logic [7:0] RSTK_STATUS_POR = 8'h7c;
  // oscillator control fields, freq select resets to the 8 MHz setting
  localparam int RSTK_SCS_LSB = 0;
  localparam int RSTK_INTERNAL_FREQ_SELECT_LSB = 4;
  localparam logic [2:0] RSTK_INTERNAL_FREQ_SELECT_8MHZ = 3'h6;
  localparam logic [7:0] RSTK_OSC_RESET = 8'h60;
  localparam logic [1:0] RSTK_SCS_PRIMARY = 2'h0;
  localparam logic [1:0] RSTK_SCS_SECONDARY = 2'h1;
  localparam logic [1:0] RSTK_BROWNOUT_ENABLE_CONFIG_SW = 2'h1;
  // osc config field encodings (crystal modes)
  localparam logic [3:0] RSTK_OSCILLATOR_CONFIG_FIELD_LP = 4'h0;
  localparam logic [3:0] RSTK_OSCILLATOR_CONFIG_FIELD_XT = 4'h1;
  localparam logic [3:0] RSTK_OSCILLATOR_CONFIG_FIELD_HS = 4'h2;
  localparam logic [3:0] RSTK_OSCILLATOR_CONFIG_FIELD_PLL = 4'h3;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int RSTK_CLK_MHZ = 100;
  localparam int RSTK_CPU_START_DELAY_NS = 100;
  localparam int RSTK_CPU_START_DELAY_CYC = (RSTK_CPU_START_DELAY_NS * RSTK_CLK_MHZ + 999) / 1000;
  localparam int RSTK_TOST_CYC = 1024;
  localparam int RSTK_TPLL_CYC = 2000;
  localparam int RSTK_TIOBST_CYC = 100;
  localparam int RSTK_MASTER_CLEAR_PIN_FILT_CYC = 20;
  // reset cause codes
  typedef enum logic [3:0] {
    RSTK_C_NONE = 4'h0,
    RSTK_C_POR = 4'h1,
    RSTK_C_MASTER_CLEAR_PIN_RUN = 4'h2,
    RSTK_C_MASTER_CLEAR_PIN_PM = 4'h3,
    RSTK_C_WDT = 4'h4,
    RSTK_C_CM = 4'h5,
    RSTK_C_BOR = 4'h6,
    RSTK_C_INSTR = 4'h7,
    RSTK_C_STKFUL = 4'h8,
    RSTK_C_STKUNF = 4'h9
  } rstk_cause_t;
  // on-chip events
  typedef struct packed {
    logic bor;
    logic cm;
    logic wdt_timeout;
    logic reset_instr;
    logic stack_full;
    logic stack_under;
    logic wdt_clear;
    logic sleep;
    logic wake;
  } rstk_evt_t;
  // clock ready flags
  typedef struct packed {
    logic osc_startup_status;
    logic high_freq_internal_stable;
    logic mid_freq_internal_stable;
    logic secondary_osc_running;
  } rstk_clkrdy_t;
endpackage

//--- core/rstk_top.sv
// module: reset source tracker and wake exit timing
`timescale 1ns/100ps
`default_nettype none
module rstk_top
  import rstk_pkg::*;
#(
  parameter int TOST_CYC = RSTK_TOST_CYC,
  parameter int TPLL_CYC = RSTK_TPLL_CYC,
  parameter int TIOBST_CYC = RSTK_TIOBST_CYC
)
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic POWER_ON,
  input wire logic MASTER_CLEAR_PIN_N,
  input wire rstk_evt_t EVT,
  input wire logic [1:0] BROWNOUT_ENABLE_CONFIG,
  input wire logic [3:0] OSCILLATOR_CONFIG_FIELD,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic DEVICE_RESET,
  output logic CPU_RUN,
  output logic INTERRUPT_PRIORITY_ENABLE,
  output logic BROWNOUT_DETECT_ENABLE,
  output rstk_clkrdy_t CLK_READY
);
  // ************************************************************
  // master clear filtering and reset cause
  // ************************************************************
  logic master_clear_pin_n;
  logic [7:0] status_q;
  logic [7:0] osc_q;
  logic [31:0] dly_q;
  logic [31:0] stab_q;
  logic [7:0] rdata_q;
  logic master_clear_pin_d1_q;
  logic in_pm;
  logic wr_status;
  logic master_clear_pin_fall;
  logic por_evt;
  rstk_cause_t cause_q;
  rstk_clkrdy_t rdy_q;
  // the pin is only ever observed, never driven: no output exists for it
  rstk_filter #(.FILT_CYC(RSTK_MASTER_CLEAR_PIN_FILT_CYC)) u_filt (
    .clk(CLK),
    .nrst(NRST),
    .pin_n(MASTER_CLEAR_PIN_N),
    .level_n(master_clear_pin_n)
  );
  typedef enum logic [1:0] {
    RSTK_S_RUN = 2'b00,
    RSTK_S_SLEEP = 2'b01,
    RSTK_S_WAKE = 2'b10
  } rstk_pm_t;
  rstk_pm_t pm_q;
  assign in_pm = (pm_q == RSTK_S_SLEEP);
  assign por_evt = POWER_ON;
  assign master_clear_pin_fall = master_clear_pin_d1_q && !master_clear_pin_n;
  assign wr_status = WR && (ADDR == RSTK_ADDR_STATUS);
  // edge tracker for filtered pin
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      master_clear_pin_d1_q <= 1'b1;
    else
      master_clear_pin_d1_q <= master_clear_pin_n;
  end
  // device reset is held while the filtered pin is low
  assign DEVICE_RESET = !master_clear_pin_n || POWER_ON || EVT.bor || EVT.cm || (EVT.wdt_timeout && !in_pm)
    || EVT.reset_instr || EVT.stack_full || EVT.stack_under;
  // last reset cause, priority by severity
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      cause_q <= RSTK_C_NONE;
    else if (por_evt)
      cause_q <= RSTK_C_POR;
    else if (EVT.bor)
      cause_q <= RSTK_C_BOR;
    else if (EVT.cm)
      cause_q <= RSTK_C_CM;
    else if (master_clear_pin_fall)
      cause_q <= in_pm ? RSTK_C_MASTER_CLEAR_PIN_PM : RSTK_C_MASTER_CLEAR_PIN_RUN;
    else if (EVT.wdt_timeout && !in_pm)
      cause_q <= RSTK_C_WDT;
    else if (EVT.reset_instr)
      cause_q <= RSTK_C_INSTR;
    else if (EVT.stack_full)
      cause_q <= RSTK_C_STKFUL;
    else if (EVT.stack_under)
      cause_q <= RSTK_C_STKUNF;
  end
  // ************************************************************
  // status register
  // ************************************************************
  // hardware updates come after the write, so an event never gets lost
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      status_q <= RSTK_STATUS_POR;
    end
    else
    begin
      if (wr_status)
      begin
        status_q[RSTK_B_INTERRUPT_PRIORITY_ENABLE] <= WDATA[RSTK_B_INTERRUPT_PRIORITY_ENABLE];
        status_q[RSTK_B_SOFTWARE_BROWNOUT_ENABLE] <= WDATA[RSTK_B_SOFTWARE_BROWNOUT_ENABLE];
        status_q[RSTK_B_CM] <= WDATA[RSTK_B_CM];
        status_q[RSTK_B_RI] <= WDATA[RSTK_B_RI];
        status_q[RSTK_B_POR] <= WDATA[RSTK_B_POR];
        status_q[RSTK_B_BOR] <= WDATA[RSTK_B_BOR];
      end
      if (por_evt)
      begin
        status_q <= RSTK_STATUS_POR;
      end
      else
      begin
        if (EVT.bor)
        begin
          // mismatch flag left alone: only a mismatch event, a status write or power-on moves it
          status_q[RSTK_B_RI] <= 1'b1;
          status_q[RSTK_B_TO] <= 1'b1;
          status_q[RSTK_B_PD] <= 1'b1;
          status_q[RSTK_B_BOR] <= 1'b0;
        end
        if (EVT.cm)
          status_q[RSTK_B_CM] <= 1'b0;
        if (EVT.reset_instr)
          status_q[RSTK_B_RI] <= 1'b0;
        if (master_clear_pin_fall)
        begin
          status_q[RSTK_B_TO] <= 1'b1;
          if (in_pm)
            status_q[RSTK_B_PD] <= 1'b0;
        end
        if (EVT.wdt_clear)
        begin
          status_q[RSTK_B_TO] <= 1'b1;
          status_q[RSTK_B_PD] <= 1'b1;
        end
        if (EVT.sleep)
        begin
          status_q[RSTK_B_TO] <= 1'b1;
          status_q[RSTK_B_PD] <= 1'b0;
        end
        if (EVT.wdt_timeout)
          status_q[RSTK_B_TO] <= 1'b0;
      end
    end
  end
  assign INTERRUPT_PRIORITY_ENABLE = status_q[RSTK_B_INTERRUPT_PRIORITY_ENABLE];
  assign BROWNOUT_DETECT_ENABLE = (BROWNOUT_ENABLE_CONFIG == RSTK_BROWNOUT_ENABLE_CONFIG_SW) && status_q[RSTK_B_SOFTWARE_BROWNOUT_ENABLE];
  // ************************************************************
  // oscillator control and wake sequencing
  // ************************************************************
  // freq select comes up on the 8 MHz internal setting
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      osc_q <= RSTK_OSC_RESET;
    else if (por_evt)
      osc_q <= RSTK_OSC_RESET;
    else if (WR && ADDR == RSTK_ADDR_OSC)
      osc_q <= {1'b0, WDATA[6:4], 2'b00, WDATA[1:0]};
  end
  logic xtal;
  logic [1:0] system_clock_select;
  assign system_clock_select = osc_q[RSTK_SCS_LSB +: 2];
  assign xtal = (system_clock_select == RSTK_SCS_PRIMARY) && (OSCILLATOR_CONFIG_FIELD == RSTK_OSCILLATOR_CONFIG_FIELD_LP
    || OSCILLATOR_CONFIG_FIELD == RSTK_OSCILLATOR_CONFIG_FIELD_XT || OSCILLATOR_CONFIG_FIELD == RSTK_OSCILLATOR_CONFIG_FIELD_HS
    || OSCILLATOR_CONFIG_FIELD == RSTK_OSCILLATOR_CONFIG_FIELD_PLL);
  logic internal_src;
  logic lf_src;
  assign internal_src = system_clock_select[1];
  assign lf_src = (osc_q[RSTK_INTERNAL_FREQ_SELECT_LSB +: 3] == 3'h0);
  // crystal wait, plus lock time in pll mode
  logic [31:0] xtal_cyc;
  logic [31:0] exit_cyc;
  assign xtal_cyc = 32'(TOST_CYC + ((OSCILLATOR_CONFIG_FIELD == RSTK_OSCILLATOR_CONFIG_FIELD_PLL) ? TPLL_CYC : 0));
  // cpu_start_delay runs alongside the oscillator wait, so a short crystal wait still costs cpu_start_delay
  assign exit_cyc = (xtal && xtal_cyc > 32'(RSTK_CPU_START_DELAY_CYC)) ? xtal_cyc : 32'(RSTK_CPU_START_DELAY_CYC);
  // power mode and exit delay: longest of cpu_start_delay and the oscillator wait
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      pm_q <= RSTK_S_RUN;
      dly_q <= 32'h0000_0000;
    end
    else
    begin
      case (pm_q)
        RSTK_S_RUN:
        begin
          if (EVT.sleep)
            pm_q <= RSTK_S_SLEEP;
        end
        RSTK_S_SLEEP:
        begin
          if (EVT.wake || master_clear_pin_fall || EVT.wdt_timeout)
          begin
            pm_q <= RSTK_S_WAKE;
            // both delays start together, so take the larger
            dly_q <= exit_cyc;
          end
        end
        RSTK_S_WAKE:
        begin
          if (dly_q <= 32'h0000_0001)
            pm_q <= RSTK_S_RUN;
          else
            dly_q <= dly_q - 32'h0000_0001;
        end
        default:
          pm_q <= RSTK_S_RUN;
      endcase
    end
  end
  assign CPU_RUN = (pm_q == RSTK_S_RUN) && !DEVICE_RESET;
  // clock ready flags; internal osc flags rise after stabilisation while running
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      rdy_q <= '0;
      stab_q <= 32'h0000_0000;
    end
    else if (pm_q == RSTK_S_SLEEP)
    begin
      rdy_q <= '0;
      stab_q <= 32'(TIOBST_CYC);
    end
    else
    begin
      if (stab_q != 32'h0000_0000)
        stab_q <= stab_q - 32'h0000_0001;
      rdy_q.osc_startup_status <= xtal && pm_q == RSTK_S_RUN;
      rdy_q.high_freq_internal_stable <= internal_src && !lf_src && osc_q[6] && stab_q == 32'h0000_0000;
      rdy_q.mid_freq_internal_stable <= internal_src && !lf_src && !osc_q[6] && stab_q == 32'h0000_0000;
      rdy_q.secondary_osc_running <= system_clock_select == RSTK_SCS_SECONDARY;
    end
  end
  assign CLK_READY = rdy_q;
  // ************************************************************
  // read port
  // ************************************************************
  logic [7:0] status_rd;
  always_comb
  begin
    status_rd = status_q;
    status_rd[RSTK_B_SOFTWARE_BROWNOUT_ENABLE] = status_q[RSTK_B_SOFTWARE_BROWNOUT_ENABLE] && BROWNOUT_ENABLE_CONFIG == RSTK_BROWNOUT_ENABLE_CONFIG_SW;
  end
  // read data valid the cycle after the strobe only
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      rdata_q <= 8'h00;
    else if (RD)
    begin
      case (ADDR)
        RSTK_ADDR_STATUS: rdata_q <= status_rd;
        RSTK_ADDR_OSC: rdata_q <= osc_q;
        RSTK_ADDR_CFG: rdata_q <= {2'b00, BROWNOUT_ENABLE_CONFIG, OSCILLATOR_CONFIG_FIELD};
        RSTK_ADDR_CLKSTAT: rdata_q <= {4'h0, rdy_q};
        RSTK_ADDR_CAUSE: rdata_q <= {4'h0, cause_q};
        default: rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end
  assign RDATA = rdata_q;
endmodule
`default_nettype wire

//--- testbench/rstk_chk_asserts.sv
// checker: port properties of the reset source tracker
`timescale 1ns/100ps
`default_nettype none
module rstk_chk
  import rstk_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic POWER_ON,
  input wire logic MASTER_CLEAR_PIN_N,
  input wire rstk_evt_t EVT,
  input wire logic [1:0] BROWNOUT_ENABLE_CONFIG,
  input wire logic [3:0] ADDR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic DEVICE_RESET,
  input wire logic BROWNOUT_DETECT_ENABLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic [5:0] low_q;
  logic [7:0] calm_q;
  // ****
  // pin history
  // ****
  // length of the current low run on the pin
  always_ff @(posedge CLK)
  begin
    if (MASTER_CLEAR_PIN_N)
      low_q <= 6'h00;
    else if (low_q != 6'h3f)
      low_q <= low_q + 6'h01;
  end
  // cycles since a low run of 10; short glitches do not restart it
  always_ff @(posedge CLK)
  begin
    if (!NRST || low_q >= 6'h0a)
      calm_q <= 8'h00;
    else if (calm_q != 8'hff)
      calm_q <= calm_q + 8'h01;
  end
  // ****
  // properties
  // ****
  // status read right after the cause
  sequence s_rs;
    RD && ADDR == RSTK_ADDR_STATUS;
  endsequence
  property p_poweron;
    POWER_ON ##1 s_rs |=> RDATA == {RSTK_STATUS_POR[7],
      RSTK_STATUS_POR[6] && BROWNOUT_ENABLE_CONFIG == RSTK_BROWNOUT_ENABLE_CONFIG_SW, RSTK_STATUS_POR[5:0]};
  endproperty
  a_poweron: assert property (p_poweron) else $error("power-on status wrong");
  property p_mismatch; EVT.cm && !POWER_ON ##1 s_rs |=> !RDATA[5]; endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch flag kept");
  property p_instr; EVT.reset_instr && !POWER_ON ##1 s_rs |=> !RDATA[4]; endproperty
  a_instr: assert property (p_instr) else $error("instruction flag kept");
  property p_timeout; EVT.wdt_timeout && !POWER_ON ##1 s_rs |=> !RDATA[3]; endproperty
  a_timeout: assert property (p_timeout) else $error("timeout flag kept");
  property p_powerdown; EVT.sleep && !EVT.wdt_timeout && !POWER_ON ##1 s_rs |=> RDATA[3:2] == 2'h2; endproperty
  a_powerdown: assert property (p_powerdown) else $error("sleep flags wrong");
  property p_brownout; EVT.bor && !POWER_ON ##1 s_rs |=> !RDATA[0]; endproperty
  a_brownout: assert property (p_brownout) else $error("brownout flag kept");
  property p_gate; (BROWNOUT_ENABLE_CONFIG != RSTK_BROWNOUT_ENABLE_CONFIG_SW) [*2] |-> !BROWNOUT_DETECT_ENABLE; endproperty
  a_gate: assert property (p_gate) else $error("software brownout not gated");
  property p_hold; low_q == 6'h1e |-> DEVICE_RESET; endproperty
  a_hold: assert property (p_hold) else $error("held pin gave no reset");
  property p_glitch; calm_q >= 8'h3c && EVT == '0 && !POWER_ON |-> !DEVICE_RESET; endproperty
  a_glitch: assert property (p_glitch) else $error("reset without cause");
endmodule
bind rstk_top rstk_chk u_chk (.CLK, .NRST, .POWER_ON, .MASTER_CLEAR_PIN_N, .EVT, .BROWNOUT_ENABLE_CONFIG,
  .ADDR, .RD, .RDATA, .DEVICE_RESET, .BROWNOUT_DETECT_ENABLE);
`default_nettype wire

//--- testbench/rstk_master_clear_pin_drv.sv
// model: external driver of the master clear pin
`timescale 1ns/100ps
`default_nettype none
module rstk_master_clear_pin_drv
(
  input wire logic clk,
  output logic pin_n
);
  // the board pull-up keeps the pin high while nobody pulls it
  initial pin_n = 1'b1;
  // pull the pin low for n cycles, then release it to the pull-up
  task automatic hold_low(input int n);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (n) @(posedge clk);
    pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// testbench: registers, events, pin and wake paths of the reset source tracker
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  import rstk_pkg::*;
  localparam int tost = 30;
  localparam int tpll = 20;
  logic clk = 1'b0, nrst = 1'b0, power_on = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic pin_n, dev_rst, cpu_run, ipe, bde, seen;
  rstk_evt_t evt = '0;
  rstk_clkrdy_t rdy;
  logic [1:0] bcfg = 2'h1;
  logic [3:0] osc_cfg = 4'h8, addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, st = 8'h7c;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  int failures = 0, checks = 0, seed = 81236, n, k;
  rstk_evt_t evt_tab[8] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h002};
  logic [3:0] cause_tab[8] = '{RSTK_C_BOR, RSTK_C_CM, RSTK_C_NONE, RSTK_C_INSTR, RSTK_C_STKFUL,
    RSTK_C_STKUNF, RSTK_C_NONE, RSTK_C_NONE};
  logic [3:0] wk_cfg[5] = '{RSTK_OSCILLATOR_CONFIG_FIELD_HS, RSTK_OSCILLATOR_CONFIG_FIELD_PLL, 4'h8, 4'h8, 4'h8};
  logic [1:0] wk_scs[5] = '{RSTK_SCS_PRIMARY, RSTK_SCS_PRIMARY, 2'h2, RSTK_SCS_SECONDARY, 2'h2};
  int wk_dly[5] = '{tost, tost + tpll, RSTK_CPU_START_DELAY_CYC, RSTK_CPU_START_DELAY_CYC, RSTK_CPU_START_DELAY_CYC};
  int wk_bit[5] = '{3, 3, 2, 0, 1};
  // short timer parameters keep the wake runs brief
  rstk_top #(.TOST_CYC(tost), .TPLL_CYC(tpll), .TIOBST_CYC(40)) u_dut (.CLK(clk), .NRST(nrst),
    .POWER_ON(power_on), .MASTER_CLEAR_PIN_N(pin_n), .EVT(evt), .BROWNOUT_ENABLE_CONFIG(bcfg),
    .OSCILLATOR_CONFIG_FIELD(osc_cfg), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .DEVICE_RESET(dev_rst), .CPU_RUN(cpu_run), .INTERRUPT_PRIORITY_ENABLE(ipe),
    .BROWNOUT_DETECT_ENABLE(bde), .CLK_READY(rdy));
  rstk_master_clear_pin_drv u_pin (.clk(clk), .pin_n(pin_n));
  always #5 clk = ~clk;
  // status model: hardware events land after the write
  function automatic logic [7:0] hw(input logic [7:0] s, input rstk_evt_t e);
    if (e.bor)
    begin
      s[4:2] = 3'h7;
      s[0] = 1'b0;
    end
    if (e.cm)
      s[5] = 1'b0;
    if (e.reset_instr)
      s[4] = 1'b0;
    if (e.wdt_timeout)
      s[3] = 1'b0;
    if (e.sleep)
      s[3:2] = 2'h2;
    if (e.wdt_clear)
      s[3:2] = 2'h3;
    return s;
  endfunction
  // register port tasks; strobes stay up until the next task or idle
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, input rstk_evt_t e);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    evt <= e;
    if (a == RSTK_ADDR_STATUS)
      st = {d[7], d[6] & (bcfg == RSTK_BROWNOUT_ENABLE_CONFIG_SW), d[5:4], st[3:2], d[1:0]};
    st = hw(st, e);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    evt <= '0;
    power_on <= 1'b0;
    exp_q.push_back(x);
  endtask
  task automatic ev(input rstk_evt_t e);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    evt <= e;
    st = hw(st, e);
    @(posedge clk);
    evt <= '0;
  endtask
  task automatic idle(input int c);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    evt <= '0;
    repeat (c) @(negedge clk);
  endtask
  task automatic close_out();
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // the read answer stands in the cycle after the strobe
  always @(posedge clk)
    rd_d <= rd;
  // pop once per answer: the macro names its expected value twice
  always @(negedge clk)
    if (rd_d)
    begin
      exp_v = exp_q.pop_front();
      `CHK("rdata", exp_v, rdata)
    end
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(RSTK_ADDR_STATUS, 8'h7c);
    rd_reg(RSTK_ADDR_OSC, 8'h60);
    rd_reg(4'hf, 8'h00);
    rd_reg(RSTK_ADDR_CFG, 8'h18);
    wr_reg(RSTK_ADDR_STATUS, 8'h00, '0);
    rd_reg(RSTK_ADDR_STATUS, st);
    bcfg <= 2'h2;
    wr_reg(RSTK_ADDR_STATUS, 8'hff, '0);
    rd_reg(RSTK_ADDR_STATUS, st);
    idle(2);
    `CHK("ipe", 1'b1, ipe)
    `CHK("bde", 1'b0, bde)
    @(posedge clk);
    bcfg <= 2'h1;
    power_on <= 1'b1;
    st = 8'h7c;
    rd_reg(RSTK_ADDR_STATUS, st);
    rd_reg(RSTK_ADDR_OSC, 8'h60);
    // firmware marks the power-on seen, then a brownout shows as flag 0 beside power-on 1
    wr_reg(RSTK_ADDR_STATUS, 8'h3f, '0);
    ev(9'h100);
    rd_reg(RSTK_ADDR_STATUS, 8'h3e);
    // random writes, each with a random event or none in the same cycle
    for (k = 0; k < 40; k++)
    begin
      n = $unsigned($random(seed)) % 9;
      wr_reg(RSTK_ADDR_STATUS, 8'($random(seed)), (n < 8) ? evt_tab[n] : '0);
      rd_reg(RSTK_ADDR_STATUS, st);
      if (n < 8 && cause_tab[n] != RSTK_C_NONE)
        rd_reg(RSTK_ADDR_CAUSE, {4'h0, cause_tab[n]});
    end
    idle(2);
    seen = 1'b0;
    fork
      u_pin.hold_low(5);
      repeat (40) @(negedge clk) seen = seen | dev_rst;
    join
    `CHK("glitch", 1'b0, seen)
    fork
      u_pin.hold_low(40);
      begin
        repeat (35) @(negedge clk);
        `CHK("hold", 1'b1, dev_rst)
      end
    join
    idle(30);
    // wake from sleep on each clock path
    for (k = 0; k < 5; k++)
    begin
      osc_cfg <= wk_cfg[k];
      wr_reg(RSTK_ADDR_OSC, {1'b0, (k == 4) ? 3'h3 : RSTK_INTERNAL_FREQ_SELECT_8MHZ, 2'h0, wk_scs[k]}, '0);
      ev(9'h002);
      idle(4);
      `CHK("asleep", 1'b0, cpu_run)
      ev(9'h001);
      for (n = 0; n < 200 && cpu_run !== 1'b1; n++)
        @(negedge clk);
      `CHK("delay", 1'b1, n + 1 >= wk_dly[k] && n <= wk_dly[k] + 3)
      idle(50);
      `CHK("ready", 1'b1, rdy[wk_bit[k]])
      rd_reg(RSTK_ADDR_CLKSTAT, 8'(1 << wk_bit[k]));
    end
    idle(2);
    close_out();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #100000;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
